// ===== rtl/htr_params.svh
// constants for the health-tested hybrid random number block
// assumes inclusion by bare name from the package, htr_rng and the testbench files
`ifndef HTR_PARAMS_SVH
`define HTR_PARAMS_SVH
`define HTR_WORD_W        32
`define HTR_STATE_W       64
`define HTR_STARTUP_BITS  256
`define HTR_RUN_LIMIT     32
`define HTR_WIN_BITS      256
`define HTR_WIN_LO        64
`define HTR_WIN_HI        192
`define HTR_SEED_BITS     64
`define HTR_LFSR_TAPS     64'hD800000000000000
`define HTR_STATE_RST     64'h0000000000000001
`endif

// ===== rtl/htr_pkg.sv
// types shared by the random number block files
// assumes htr_params.svh on the include path
`include "htr_params.svh"
package htr_pkg;
    typedef enum logic [3:0] {
        HTR_ST_STARTUP = 4'b0001,
        HTR_ST_SEED    = 4'b0010,
        HTR_ST_RUN     = 4'b0100,
        HTR_ST_FAIL    = 4'b1000
    } htr_state_t;
endpackage : htr_pkg

// ===== rtl/htr_skid.sv
// two-entry buffer with valid and ready on both sides
// assumes one clock, synchronous active-high reset, clock enable freezes all
`timescale 1ns/1ps
module htr_skid #(
    parameter int WIDTH = 32
) (
    // clock and control
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             flush,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    logic [WIDTH-1:0] mem_r [2];
    logic [WIDTH-1:0] mem_nxt [2];
    logic [1:0] cnt_r, cnt_nxt;
    logic       rd_r, rd_nxt, wr_r, wr_nxt;
    logic       push, pop;

    // elaboration-time guard on the word width
    if (WIDTH < 1) begin : g_bad_width
        $error("htr_skid: WIDTH must be positive");
    end

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_r];

    // pointer and occupancy update; flush discards words that may be tainted
    always_comb begin
        mem_nxt = mem_r;
        cnt_nxt = cnt_r;
        rd_nxt  = rd_r;
        wr_nxt  = wr_r;
        if (flush) begin
            cnt_nxt = 2'h0;
            rd_nxt  = 1'b0;
            wr_nxt  = 1'b0;
        end else begin
            if (push) begin
                mem_nxt[wr_r] = in_data;
                wr_nxt        = ~wr_r;
            end
            if (pop) rd_nxt = ~rd_r;
            cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= 2'h0;
            rd_r  <= 1'b0;
            wr_r  <= 1'b0;
        end else if (clk_en) begin
            mem_r <= mem_nxt;
            cnt_r <= cnt_nxt;
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
        end
    end
endmodule : htr_skid

// ===== rtl/htr_rng.sv
// health-tested hybrid random number block: raw entropy bits are checked
// by start-up and continuous tests, seed a deterministic generator, and
// the generator's 32-bit words leave through a two-entry buffer.
// assumes the raw entropy bit arrives asynchronously from an analogue source
`timescale 1ns/1ps
`include "htr_params.svh"

module htr_rng
    import htr_pkg::*;
#(
    parameter int STARTUP_BITS = `HTR_STARTUP_BITS,
    parameter int RUN_LIMIT    = `HTR_RUN_LIMIT,
    parameter int WIN_BITS     = `HTR_WIN_BITS,
    parameter int WIN_LO       = `HTR_WIN_LO,
    parameter int WIN_HI       = `HTR_WIN_HI,
    parameter int SEED_BITS    = `HTR_SEED_BITS
) (
    // clock and control
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,
    // entropy source
    input  wire logic                   raw_bit,
    input  wire logic                   raw_strobe,
    // reseed request
    input  wire logic                   reseed_req,
    // random word stream
    output logic                        rnd_valid,
    input  wire logic                   rnd_ready,
    output logic [`HTR_WORD_W-1:0]      rnd_data,
    // status
    output logic                        rng_ok,
    output logic                        err_total,
    output logic                        err_defect
);
    localparam int SW = `HTR_STATE_W;
    localparam int WW = `HTR_WORD_W;

    // elaboration-time guard: run counter is 8 bits, window and bit counters 16 bits
    if (RUN_LIMIT < 2 || RUN_LIMIT > 255 || WIN_BITS < 2 || WIN_BITS > 65535 ||
        WIN_LO >= WIN_HI || WIN_HI > WIN_BITS || SEED_BITS < 1 || SEED_BITS > 65535 ||
        STARTUP_BITS < 1 || STARTUP_BITS > 65535) begin : g_bad_params
        $error("htr_rng: parameter out of range");
    end

    // three-stage synchroniser for the asynchronous entropy pins
    logic [2:0] bit_sy_r, stb_sy_r;
    logic       bit_s, stb_s, stb_d_r, take;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bit_sy_r <= 3'h0;
            stb_sy_r <= 3'h0;
            stb_d_r  <= 1'b0;
        end else if (clk_en) begin
            bit_sy_r <= {bit_sy_r[1:0], raw_bit};
            stb_sy_r <= {stb_sy_r[1:0], raw_strobe};
            stb_d_r  <= stb_s;
        end
    end
    // a change counts only once stages two and three agree
    assign stb_s = (stb_sy_r[1] == stb_sy_r[2]) ? stb_sy_r[2] : stb_d_r;
    assign bit_s = bit_sy_r[2];
    assign take  = stb_s && !stb_d_r;                   // one raw bit per rising strobe edge

    // health tests: repetition run (total failure) and windowed ones count
    logic [7:0]  run_r, run_nxt;
    logic        last_r, last_nxt;
    logic [15:0] win_r, win_nxt, ones_r, ones_nxt;
    logic        tot_fail, win_end, win_bad;
    always_comb begin
        run_nxt  = run_r;
        last_nxt = last_r;
        win_nxt  = win_r;
        ones_nxt = ones_r;
        tot_fail = 1'b0;
        win_end  = 1'b0;
        win_bad  = 1'b0;
        if (take) begin
            last_nxt = bit_s;
            run_nxt  = (bit_s == last_r) ? run_r + 8'h01 : 8'h01;
            tot_fail = (bit_s == last_r) && (run_r >= 8'(RUN_LIMIT - 1));
            ones_nxt = ones_r + {15'h0000, bit_s};
            win_nxt  = win_r + 16'h0001;
            if (win_r == 16'(WIN_BITS - 1)) begin
                win_end  = 1'b1;
                win_bad  = (ones_nxt < 16'(WIN_LO)) || (ones_nxt > 16'(WIN_HI));
                win_nxt  = 16'h0000;
                ones_nxt = 16'h0000;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            run_r  <= 8'h00;
            last_r <= 1'b0;
            win_r  <= 16'h0000;
            ones_r <= 16'h0000;
        end else if (clk_en) begin
            run_r  <= run_nxt;
            last_r <= last_nxt;
            win_r  <= win_nxt;
            ones_r <= ones_nxt;
        end
    end

    // control: start-up test, seeding, running, locked failure
    htr_state_t  st_r, st_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic        pend_r, pend_nxt, etot_r, etot_nxt, edef_r, edef_nxt;
    logic [SW-1:0] dstate_r, dstate_nxt;
    logic [SW-1:0] seed_r, seed_nxt;
    logic        gen_push, buf_ready, flush, fail_now;
    logic        fb;
    assign fb       = ^(dstate_r & `HTR_LFSR_TAPS);
    assign fail_now = tot_fail || win_bad;
    always_comb begin
        st_nxt     = st_r;
        cnt_nxt    = cnt_r;
        pend_nxt   = pend_r || reseed_req;
        etot_nxt   = etot_r || tot_fail;
        edef_nxt   = edef_r || win_bad;
        dstate_nxt = dstate_r;
        seed_nxt   = seed_r;
        gen_push   = 1'b0;
        flush      = fail_now;
        if (take) seed_nxt = {seed_r[SW-2:0], bit_s};
        unique case (st_r)
            HTR_ST_STARTUP: begin
                if (take) cnt_nxt = cnt_r + 16'h0001;
                // pass requires a full clean window and the start-up bit count
                if (win_end && !win_bad && cnt_r >= 16'(STARTUP_BITS - 1)) begin
                    st_nxt  = HTR_ST_SEED;
                    cnt_nxt = 16'h0000;
                end
            end
            HTR_ST_SEED: begin
                if (take) cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r >= 16'(SEED_BITS)) begin
                    dstate_nxt = dstate_r ^ seed_r;
                    if (dstate_nxt == '0) dstate_nxt = `HTR_STATE_RST;
                    pend_nxt   = reseed_req;
                    cnt_nxt    = 16'h0000;
                    st_nxt     = HTR_ST_RUN;
                end
            end
            HTR_ST_RUN: begin
                if (pend_r) begin
                    st_nxt  = HTR_ST_SEED;
                    cnt_nxt = 16'h0000;
                end else if (buf_ready) begin
                    dstate_nxt = {dstate_r[SW-2:0], fb};
                    cnt_nxt    = cnt_r + 16'h0001;
                    // one word per WW steps so bits do not overlap between words
                    if (cnt_r == 16'(WW - 1)) begin
                        gen_push = 1'b1;
                        cnt_nxt  = 16'h0000;
                    end
                end
            end
            HTR_ST_FAIL: begin
                flush = 1'b1;
            end
        endcase
        if (fail_now) begin
            st_nxt   = HTR_ST_FAIL;
            gen_push = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r     <= HTR_ST_STARTUP;
            cnt_r    <= 16'h0000;
            pend_r   <= 1'b0;
            etot_r   <= 1'b0;
            edef_r   <= 1'b0;
            dstate_r <= `HTR_STATE_RST;
            seed_r   <= '0;
        end else if (clk_en) begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            pend_r   <= pend_nxt;
            etot_r   <= etot_nxt;
            edef_r   <= edef_nxt;
            dstate_r <= dstate_nxt;
            seed_r   <= seed_nxt;
        end
    end

    // output buffer; outputs are registered copies for a clean flop boundary
    logic          b_valid, b_pop;
    logic [WW-1:0] b_data;
    logic          ov_r, ov_nxt, ok_r, ok_nxt;
    logic [WW-1:0] od_r, od_nxt;
    htr_skid #(.WIDTH(WW)) u_buf (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .flush     (flush),
        .in_valid  (gen_push),
        .in_ready  (buf_ready),
        .in_data   (dstate_r[WW-1:0]),
        .out_valid (b_valid),
        .out_ready (b_pop),
        .out_data  (b_data)
    );
    // output stage refills when empty or consumed; a flush clears it and blocks refills
    assign b_pop = (!ov_r || rnd_ready) && !flush;
    always_comb begin
        ov_nxt = ov_r;
        od_nxt = od_r;
        if (flush) ov_nxt = 1'b0;
        else if (b_pop) begin
            ov_nxt = b_valid;
            if (b_valid) od_nxt = b_data;
        end
        ok_nxt = (st_nxt == HTR_ST_RUN) || (st_nxt == HTR_ST_SEED && ok_r);
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ov_r <= 1'b0;
            od_r <= '0;
            ok_r <= 1'b0;
        end else if (clk_en) begin
            ov_r <= ov_nxt;
            od_r <= od_nxt;
            ok_r <= ok_nxt;
        end
    end
    assign rnd_valid  = ov_r;
    assign rnd_data   = od_r;
    assign rng_ok     = ok_r;
    assign err_total  = etot_r;
    assign err_defect = edef_r;
endmodule : htr_rng

// ===== testbench/htr_rng_asserts.sv
// concurrent checks on the random word stream, blocking and status flags
// assumes binding onto htr_rng; one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "htr_params.svh"
module htr_rng_asserts #(
    parameter int STARTUP_BITS = 256,
    parameter int WIN_BITS     = 256,
    parameter int SEED_BITS    = 64
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   sys_rst,
    // entropy strobe
    input wire logic                   raw_strobe,
    // word stream and status
    input wire logic                   rnd_valid,
    input wire logic                   rnd_ready,
    input wire logic [`HTR_WORD_W-1:0] rnd_data,
    input wire logic                   rng_ok,
    input wire logic                   err_total,
    input wire logic                   err_defect
);
    localparam int MIN_BITS = (STARTUP_BITS > WIN_BITS ? STARTUP_BITS : WIN_BITS) + SEED_BITS;
    logic strobe_q_r;
    logic strobe_q_nxt;
    int   rises_r;
    int   rises_nxt;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // strobe rises since reset; counted unsynchronised, so an upper bound
    always_comb begin
        strobe_q_nxt = raw_strobe;
        rises_nxt    = rises_r + int'(raw_strobe && !strobe_q_r);
    end
    always_ff @(posedge clk) begin
        strobe_q_r <= sys_rst ? 1'b0 : strobe_q_nxt;
        rises_r    <= sys_rst ? 0 : rises_nxt;
    end
    chk_err_total_sticky: assert property (err_total |=> err_total)
        else $error("total failure flag cleared without reset");
    chk_err_defect_sticky: assert property (err_defect |=> err_defect)
        else $error("defect flag cleared without reset");
    chk_blocked_before_ok: assert property ((!rng_ok && !err_total && !err_defect) |-> !rnd_valid)
        else $error("word offered before start-up pass");
    chk_word_holds: assert property ((rnd_valid && !rnd_ready && !err_total && !err_defect)
        |=> (rnd_valid && $stable(rnd_data)) || err_total || err_defect)
        else $error("offered word changed or vanished");
    // flags, flush and status all change at the same edge, so no grace cycles
    chk_fail_blocks: assert property ((err_total || err_defect) |-> !rnd_valid && !rng_ok)
        else $error("output not blocked after failure");
    chk_reset_quiet: assert property (disable iff (1'b0)
        sys_rst |=> !rnd_valid && !rng_ok && !err_total && !err_defect)
        else $error("outputs not cleared by reset");
    chk_ok_stays_up: assert property (rng_ok |=> rng_ok || err_total || err_defect)
        else $error("ready status dropped without failure");
    chk_startup_bits: assert property ($rose(rng_ok) |-> rises_r >= MIN_BITS)
        else $error("start-up passed on too few raw bits");
endmodule : htr_rng_asserts

bind htr_rng htr_rng_asserts #(.STARTUP_BITS(STARTUP_BITS), .WIN_BITS(WIN_BITS),
    .SEED_BITS(SEED_BITS)) i_htr_rng_asserts (.clk(clk), .sys_rst(sys_rst),
    .raw_strobe(raw_strobe), .rnd_valid(rnd_valid), .rnd_ready(rnd_ready),
    .rnd_data(rnd_data), .rng_ok(rng_ok), .err_total(err_total), .err_defect(err_defect));

// ===== testbench/htr_sink.sv
// consumer of random words that stalls a set number of cycles after each take
// assumes the same clock and reset as the block
`timescale 1ns/1ps
`include "htr_params.svh"
module htr_sink (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,   // block frozen while low: no take then
    // cycles of stall after each word
    input  wire logic [31:0]            stall,
    // word stream
    input  wire logic                   rnd_valid,
    output logic                        rnd_ready,
    input  wire logic [`HTR_WORD_W-1:0] rnd_data,
    // record of taken words
    output int                          n_taken,
    output logic [`HTR_WORD_W-1:0]      last_w,
    output logic [`HTR_WORD_W-1:0]      prev_w
);
    int wait_r;
    // ready drops after a take when stall is nonzero, so long stalls let the block's queue fill
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rnd_ready <= 1'b0;
            n_taken   <= 0;
            wait_r    <= 0;
        end else if (rnd_valid && rnd_ready && clk_en) begin
            n_taken   <= n_taken + 1;
            prev_w    <= last_w;
            last_w    <= rnd_data;
            wait_r    <= stall;
            rnd_ready <= (stall == 0);
        end else if (wait_r > 0) begin
            wait_r    <= wait_r - 1;
            rnd_ready <= (wait_r == 1);
        end else begin
            rnd_ready <= 1'b1;
        end
    end
endmodule : htr_sink

// ===== testbench/health_tested_hybrid_rng_test.sv
// self-checking bench: start-up, word stream rows, reseed, failures
// assumes shortened health-test counts so start-up takes a few hundred cycles
`timescale 1ns/1ps
`include "htr_params.svh"
module health_tested_hybrid_rng_test;
    typedef struct { int stall; bit reseed; bit pause; logic ok; } htr_row_t;
    htr_row_t rows [4] = '{'{0, 0, 0, 1'b1}, '{3, 1, 0, 1'b1}, '{40, 0, 1, 1'b1}, '{1, 1, 0, 1'b1}};
    logic                   clk        = 1'b0;
    logic                   sys_rst    = 1'b1;
    logic                   clk_en     = 1'b1;
    logic                   raw_bit    = 1'b0;
    logic                   raw_strobe = 1'b0;
    logic                   reseed_req = 1'b0;
    logic                   src_stuck  = 1'b0;
    int                     stall      = 0;
    int                     mismatches = 0;
    int                     n_compared = 0;
    int                     n_taken;
    logic                   rnd_valid, rnd_ready, rng_ok, err_total, err_defect;
    logic [`HTR_WORD_W-1:0] rnd_data, last_w, prev_w;
    htr_rng #(.STARTUP_BITS(8), .WIN_BITS(16), .WIN_LO(2), .WIN_HI(14),
        .SEED_BITS(8)) i_htr_rng (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .raw_bit(raw_bit), .raw_strobe(raw_strobe), .reseed_req(reseed_req),
        .rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .rnd_data(rnd_data),
        .rng_ok(rng_ok), .err_total(err_total), .err_defect(err_defect));
    htr_sink i_htr_sink (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .stall(stall),
        .rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .rnd_data(rnd_data), .n_taken(n_taken),
        .last_w(last_w), .prev_w(prev_w));
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    // entropy source: alternating bits, or stuck high to fake a dead source
    initial begin
        forever begin
            @(posedge clk);
            raw_bit <= src_stuck ? 1'b1 : ~raw_bit;
            repeat (4) @(posedge clk);
            raw_strobe <= 1'b1;
            repeat (4) @(posedge clk);
            raw_strobe <= 1'b0;
        end
    end
    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic take(input int n);
        int tgt;
        tgt = n_taken + n;
        for (int i = 0; i < 3000 && n_taken < tgt; i++) @(posedge clk);
        chk(n_taken >= tgt, "words not delivered");
    endtask : take
    task automatic wait_cycles_until_err(input int lim);
        for (int i = 0; i < lim && err_total !== 1'b1; i++) @(posedge clk);
    endtask : wait_cycles_until_err
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    // watchdog, well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
    // main sequence
    initial begin
        repeat (19) @(posedge clk);
        chk(rnd_valid === 1'b0 && rng_ok === 1'b0 && err_total === 1'b0, "reset state");
        @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 1000 && rng_ok !== 1'b1; i++) @(posedge clk);
        chk(rng_ok === 1'b1 && err_defect === 1'b0, "start-up did not pass");
        $display("start-up test done");
        foreach (rows[k]) begin
            stall <= rows[k].stall;
            if (rows[k].reseed) begin
                reseed_req <= 1'b1;
                @(posedge clk);
                reseed_req <= 1'b0;
            end
            if (rows[k].pause) begin
                clk_en <= 1'b0;
                repeat (6) @(posedge clk);
                clk_en <= 1'b1;
            end
            take(4);
            chk(rng_ok === rows[k].ok && err_total === 1'b0, "row status");
            chk(last_w !== prev_w && ^last_w !== 1'bx, "row words");
            $display("row %0d done", k);
        end
        // source dies in operation: flag within a bounded time, output blocked
        stall <= 40;
        src_stuck <= 1'b1;
        // default run limit of 32 equal bits at 9 cycles per raw bit, plus sync delay
        wait_cycles_until_err(450);
        chk(err_total === 1'b1, "dead source not seen");
        repeat (3) @(posedge clk);
        chk(rnd_valid === 1'b0 && rng_ok === 1'b0, "output after failure");
        src_stuck <= 1'b0;
        repeat (200) @(posedge clk);
        chk(err_total === 1'b1 && rnd_valid === 1'b0, "failure not sticky");
        $display("run failure test done");
        // dead source from start-up: no word may ever appear
        sys_rst <= 1'b1;
        src_stuck <= 1'b1;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        wait_cycles_until_err(600);
        chk(err_total === 1'b1 && rng_ok === 1'b0 && rnd_valid === 1'b0, "start-up fail");
        // an all-ones window of 16 bits lies above the upper ones bound of 14
        chk(err_defect === 1'b1, "start-up window defect not seen");
        $display("start-up failure test done");
        results();
    end
endmodule : health_tested_hybrid_rng_test
